/* rtl/fabi_pkg.sv */
// constants for the host side of the asynchronous flash bus controller
// assumes a 50 MHz ref_clk; times are printed in ns and converted here
// Notes on behaviour
// - reset low minimum, then wait recovery times
// - host waits ready after reset before cycles
// - read: select and output enable low, strobe high
// - output enable high throughout write
package fabi_pkg;
   localparam int CLK_PERIOD_NS = 20;
   // timing figures, plain defaults where none is printed
   localparam int RESET_LOW_MIN_TIME_NS = 500;
   localparam int RESET_HIGH_TO_SELECT_TIME_NS = 50;
   localparam int READY_TO_SELECT_TIME_NS = 0;
   localparam int READ_ACCESS_NS = 55;
   localparam int WRITE_PULSE_NS = 40;
   localparam int SETUP_NS = 20;
   // least times round up; the two recovery times never below one cycle
   localparam int RESET_LOW_CYC = (RESET_LOW_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_REC_CYC_RAW = (RESET_HIGH_TO_SELECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_REC_CYC = (RESET_REC_CYC_RAW < 1) ? 1 : RESET_REC_CYC_RAW;
   localparam int READY_REC_CYC_RAW = (READY_TO_SELECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READY_REC_CYC = (READY_REC_CYC_RAW < 1) ? 1 : READY_REC_CYC_RAW;
   localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int WRITE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   // pin widths
   localparam int ADDR_W = 17;
   localparam int DATA_W = 16;
   // bottom-boot block starts, word addresses
   localparam logic [16:0] BLK1_WORD = 17'h02000;
   localparam logic [16:0] BLK2_WORD = 17'h03000;
   localparam logic [16:0] BLK3_WORD = 17'h04000;
   localparam logic [16:0] BLK4_WORD = 17'h08000;
   localparam logic [16:0] BLK5_WORD = 17'h10000;
   localparam logic [16:0] BLK6_WORD = 17'h18000;
   localparam logic [15:0] ERASED_WORD = 16'hFFFF;
   localparam logic [15:0] DATA_RST = 16'h0000;
   typedef enum logic [1:0] {FABI_OP_READ, FABI_OP_WRITE, FABI_OP_RESET} fabi_op_type;
   typedef enum {FABI_ST_IDLE, FABI_ST_RST_LOW, FABI_ST_RST_REC, FABI_ST_RD, FABI_ST_WR_SETUP,
      FABI_ST_WR_PULSE, FABI_ST_WR_HOLD, FABI_ST_DONE} fabi_state_type;
endpackage

/* rtl/fabi_sync.sv */
// two-flop synchroniser for one pin level
// assumes the input is asynchronous to ref_clk
`timescale 1ns/1ps
module fabi_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // level in and out
   input wire logic async_in,
   output logic sync_out
);
   logic meta_r;

   // first flop read only by the second
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule

/* rtl/fabi_host.sv */
// host controller driving the flash asynchronous bus pins
// assumes one request at a time; ready/busy pulled up externally
`timescale 1ns/1ps
module fabi_host
   import fabi_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // user request
   input wire logic req_valid,
   input wire fabi_pkg::fabi_op_type req_op,
   input wire logic [fabi_pkg::ADDR_W-1:0] req_addr,
   input wire logic req_byte_high,
   input wire logic [fabi_pkg::DATA_W-1:0] req_wdata,
   input wire logic word_mode,
   output logic req_ready,
   // user answer
   output logic rsp_valid,
   output logic [fabi_pkg::DATA_W-1:0] rsp_rdata,
   output logic dev_busy,
   // flash pins
   output logic [fabi_pkg::ADDR_W-1:0] address_lines,
   output logic chip_select_n,
   output logic output_enable_n,
   output logic write_strobe_n,
   output logic reset_or_unprotect_n,
   output logic byte_word_sel,
   input wire logic [fabi_pkg::DATA_W-1:0] data_in,
   output logic [fabi_pkg::DATA_W-1:0] data_out,
   output logic data_oe,
   output logic top_data_or_low_address_oe,
   input wire logic ready_busy_od
);
   import fabi_pkg::*;

   fabi_state_type state_r;
   logic [CNT_W-1:0] cnt_r;
   logic rb_sync;
   logic [DATA_W-1:0] data_s;
   logic take;

   // take only when idle and ready, never the request answered this cycle
   assign take = (state_r == FABI_ST_IDLE) && req_valid && rb_sync && !rsp_valid;

   // pins pass two flops before use
   fabi_sync #(.RESET_VAL(1'b1)) u_rb (.ref_clk(ref_clk), .rst_b(rst_b), .async_in(ready_busy_od),
      .sync_out(rb_sync));
   for (genvar i = 0; i < DATA_W; i++) begin : g_dsync
      fabi_sync #(.RESET_VAL(1'b0)) u_d (.ref_clk(ref_clk), .rst_b(rst_b), .async_in(data_in[i]),
         .sync_out(data_s[i]));
   end

   // main sequencer; all pins change on clock edges, no glitches
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= FABI_ST_RST_LOW;
         cnt_r <= '0;
      end else begin
         unique case (state_r)
            FABI_ST_IDLE: begin
               cnt_r <= '0;
               if (take) begin
                  unique case (req_op)
                     FABI_OP_READ: begin
                        state_r <= FABI_ST_RD;
                     end
                     FABI_OP_WRITE: begin
                        state_r <= FABI_ST_WR_SETUP;
                     end
                     default: begin
                        state_r <= FABI_ST_RST_LOW;
                     end
                  endcase
               end
            end
            FABI_ST_RST_LOW: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == CNT_W'(RESET_LOW_CYC - 1)) begin
                  state_r <= FABI_ST_RST_REC;
                  cnt_r <= '0;
               end
            end
            FABI_ST_RST_REC: begin
               // sum of both recovery times plus two cycles, then ready release
               if (cnt_r < CNT_W'(RESET_REC_CYC + READY_REC_CYC + 2)) begin
                  cnt_r <= cnt_r + 1'b1;
               end else if (rb_sync) begin
                  state_r <= FABI_ST_IDLE;
                  cnt_r <= '0;
               end
            end
            FABI_ST_RD: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == CNT_W'(READ_CYC + 1)) begin
                  state_r <= FABI_ST_DONE;
               end
            end
            FABI_ST_WR_SETUP: begin
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == CNT_W'(SETUP_CYC - 1)) begin
                  state_r <= FABI_ST_WR_PULSE;
                  cnt_r <= '0;
               end
            end
            FABI_ST_WR_PULSE: begin
               // strobe low longer than any glitch filter
               cnt_r <= cnt_r + 1'b1;
               if (cnt_r == CNT_W'(WRITE_CYC - 1)) begin
                  state_r <= FABI_ST_WR_HOLD;
                  cnt_r <= '0;
               end
            end
            FABI_ST_WR_HOLD: begin
               state_r <= FABI_ST_DONE;
            end
            FABI_ST_DONE: begin
               state_r <= FABI_ST_IDLE;
            end
         endcase
      end
   end

   // latched request fields and pin drive
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         address_lines <= '0;
         data_out <= DATA_RST;
         byte_word_sel <= 1'b1;
      end else if (take) begin
         address_lines <= req_addr;
         byte_word_sel <= word_mode;
         // byte mode: top pin carries byte select
         data_out <= word_mode ? req_wdata : {req_byte_high, 7'h00, req_wdata[7:0]};
      end
   end

   // control strobes, all registered
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         chip_select_n <= 1'b1;
         output_enable_n <= 1'b1;
         write_strobe_n <= 1'b1;
         reset_or_unprotect_n <= 1'b0;
         data_oe <= 1'b0;
         top_data_or_low_address_oe <= 1'b0;
      end else begin
         reset_or_unprotect_n <= !(state_r == FABI_ST_RST_LOW || (take && req_op == FABI_OP_RESET));
         chip_select_n <= !(state_r == FABI_ST_RD || state_r == FABI_ST_WR_SETUP ||
            state_r == FABI_ST_WR_PULSE);
         output_enable_n <= !(state_r == FABI_ST_RD);
         write_strobe_n <= !(state_r == FABI_ST_WR_PULSE);
         // write data held across the strobe rising edge
         data_oe <= (state_r == FABI_ST_WR_SETUP || state_r == FABI_ST_WR_PULSE ||
            state_r == FABI_ST_WR_HOLD);
         top_data_or_low_address_oe <= (state_r == FABI_ST_WR_SETUP || state_r == FABI_ST_WR_PULSE ||
            state_r == FABI_ST_WR_HOLD) || (!byte_word_sel && state_r == FABI_ST_RD);
      end
   end

   // answer and status
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
         req_ready <= 1'b0;
         dev_busy <= 1'b1;
      end else begin
         rsp_valid <= (state_r == FABI_ST_DONE);
         if (state_r == FABI_ST_RD && cnt_r == CNT_W'(READ_CYC + 1)) begin
            // byte mode: upper lines float, drop them
            rsp_rdata <= byte_word_sel ? data_s : {8'h00, data_s[7:0]};
         end
         req_ready <= (state_r == FABI_ST_IDLE) && rb_sync && !req_valid;
         dev_busy <= !rb_sync;
      end
   end

   // pin low time kept in a counter, too long for a repetition
   logic [CNT_W-1:0] rst_low_cnt_r;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_low_cnt_r <= '0;
      end else if (reset_or_unprotect_n) begin
         rst_low_cnt_r <= '0;
      end else if (rst_low_cnt_r != '1) begin
         // saturate so a stuck reset cannot wrap to a short count
         rst_low_cnt_r <= rst_low_cnt_r + 1'b1;
      end
   end

   // write strobe low lasts the full pulse count
   sequence s_wr_start;
      $fell(write_strobe_n);
   endsequence
   sequence s_wr_pulse;
      !write_strobe_n [*2];
   endsequence
   AST_WR_PULSE_WIDTH: assert property (@(posedge ref_clk) disable iff (!rst_b)
      s_wr_start |-> s_wr_pulse) else $error("write pulse too short");
   AST_OE_HIGH_IN_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !write_strobe_n |-> output_enable_n) else $error("output enable low during write");
   AST_WR_SELECTED: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $fell(write_strobe_n) |-> !chip_select_n && $past(!chip_select_n)) else $error("select not ahead of strobe");
   AST_DATA_HELD: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(write_strobe_n) |-> data_oe && $stable(data_out)) else $error("data not held at strobe rise");
   AST_READ_SHAPE: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !output_enable_n |-> !chip_select_n && write_strobe_n && !data_oe) else $error("bad read pin state");
   AST_RESET_WIDTH: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $fell(reset_or_unprotect_n) |-> !reset_or_unprotect_n [*8]) else $error("reset pulse too short");
   AST_NO_CYCLE_BUSY: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $fell(chip_select_n) |-> $past(rb_sync, 2)) else $error("cycle started while busy");
   AST_NO_CYCLE_IN_RESET: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !reset_or_unprotect_n |-> chip_select_n) else $error("select during reset");
   AST_RSP_AFTER_READ: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(output_enable_n) |-> rsp_valid) else $error("read answer missing");
   AST_RESET_FULL_WIDTH: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(reset_or_unprotect_n) |-> $past(rst_low_cnt_r) >= CNT_W'(RESET_LOW_CYC))
      else $error("reset low too short");
   // the answered request still stands on req_valid for one edge
   AST_NO_RETAKE: assert property (@(posedge ref_clk) disable iff (!rst_b)
      rsp_valid |=> chip_select_n && reset_or_unprotect_n) else $error("answered request taken again");
endmodule

/* testbench/fabi_flash_model.sv */
// behavioural flash device on the pin side of the host controller
// assumes direct wiring to the host pins; returns resolved pin levels
`timescale 1ns/1ps
module fabi_flash_model #(
   parameter int ACC_NS = 55,
   parameter int REC_NS = 200,
   parameter int PROG_NS = 300,
   parameter int RST_MIN_NS = 500
) (
   // pins from the host
   input wire logic [16:0] address_lines,
   input wire logic chip_select_n,
   input wire logic output_enable_n,
   input wire logic write_strobe_n,
   input wire logic reset_or_unprotect_n,
   input wire logic byte_word_sel,
   input wire logic [15:0] data_out,
   input wire logic data_oe,
   input wire logic top_data_or_low_address_oe,
   // resolved levels back to the host
   output logic [15:0] data_in,
   output logic ready_busy_od,
   output int host_faults
);
   logic [15:0] mem [0:131071];
   logic [15:0] word, dev_val, dev_en, host_en, flt = 16'h5A5A;
   logic [17:0] lat;
   logic wr_act = 1'b0, lat_byte, rec = 1'b0, prog = 1'b0, rd_on, rd_dly, pin15;
   realtime t_low = 0, t_wr = 0;
   event prog_ev;
   // delivered erased; seven blocks span the whole word range
   initial foreach (mem[i]) mem[i] = 16'hFFFF;
   initial host_faults = 0;
   // floating lines change every cycle so stale data never passes
   always #20 flt = ~flt;
   // read needs select and output enable low, strobe high, device idle
   assign rd_on = !chip_select_n && !output_enable_n && write_strobe_n && reset_or_unprotect_n && !rec && !prog;
   assign #(ACC_NS) rd_dly = rd_on;
   assign pin15 = top_data_or_low_address_oe ? data_out[15] : flt[15];
   assign word = mem[address_lines];
   assign dev_val = byte_word_sel ? word : {8'h00, pin15 ? word[15:8] : word[7:0]};
   assign dev_en = (rd_on && rd_dly) ? (byte_word_sel ? 16'hFFFF : 16'h00FF) : 16'h0000;
   assign host_en = {top_data_or_low_address_oe | (data_oe & byte_word_sel), {15{data_oe}}};
   assign data_in = (host_en & data_out) | (~host_en & dev_en & dev_val) | (~host_en & ~dev_en & flt);
   // open drain with pull-up: low while resetting or programming
   assign ready_busy_od = reset_or_unprotect_n && !rec && !prog;
   // reset pulse width, then recovery before ready
   always @(negedge reset_or_unprotect_n) t_low = $realtime;
   always @(posedge reset_or_unprotect_n) begin
      if ($realtime - t_low < RST_MIN_NS) host_faults++;
      rec = 1'b1;
      #(REC_NS) rec = 1'b0;
   end
   // host timing faults are counted, not forgiven
   always @(negedge chip_select_n) if (!reset_or_unprotect_n || rec) host_faults++;
   always @(negedge output_enable_n) if (wr_act) host_faults++;
   // address on the later fall of select or strobe
   always @(negedge chip_select_n or negedge write_strobe_n)
      if (!chip_select_n && !write_strobe_n && reset_or_unprotect_n) begin
         lat = {address_lines, pin15};
         lat_byte = !byte_word_sel;
         wr_act = 1'b1;
         t_wr = $realtime;
      end
   // data on the earlier rise; commands out of scope, a write programs
   always @(posedge chip_select_n or posedge write_strobe_n)
      if (wr_act) begin
         wr_act = 1'b0;
         // a low pulse under 5 ns is a glitch: nothing is programmed
         if ($realtime - t_wr >= 5.0) begin
            if (lat_byte) mem[lat[17:1]] = mem[lat[17:1]] &
               (lat[0] ? {data_in[7:0], 8'hFF} : {8'hFF, data_in[7:0]});
            else mem[lat[17:1]] = mem[lat[17:1]] & data_in;
            -> prog_ev;
         end
      end
   // programming only clears bits and holds busy meanwhile
   always @(prog_ev) begin
      prog = 1'b1;
      #(PROG_NS) prog = 1'b0;
   end
endmodule

/* testbench/testbench.sv */
// self-checking bench for the flash bus host controller
// assumes the behavioural flash model stands on the pin side
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("ERROR %0t: got %h want %h", $time, g, e); end end
module testbench;
   import fabi_pkg::*;
   logic ref_clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_byte_high = 1'b0, word_mode = 1'b1;
   fabi_op_type req_op = FABI_OP_READ;
   logic [ADDR_W-1:0] req_addr = 17'h00000, address_lines, a;
   logic [DATA_W-1:0] req_wdata = 16'h0000, rsp_rdata, data_in, data_out, d;
   logic req_ready, rsp_valid, dev_busy, chip_select_n, output_enable_n, write_strobe_n, bh, busy_seen = 1'b0;
   logic reset_or_unprotect_n, byte_word_sel, data_oe, top_data_or_low_address_oe, ready_busy_od;
   logic [15:0] exp_mem [int];
   logic [16:0] edges [8] = '{17'h00000, BLK1_WORD, BLK2_WORD, BLK3_WORD, BLK4_WORD, BLK5_WORD, BLK6_WORD, 17'h1FFFF};
   int fail_count = 0, total_checks = 0, cycles = 0, low_cnt = 0, host_faults;
   always #10 ref_clk = ~ref_clk;
   fabi_host fabi_host_i (.ref_clk, .rst_b, .req_valid, .req_op, .req_addr, .req_byte_high, .req_wdata, .word_mode,
      .req_ready, .rsp_valid, .rsp_rdata, .dev_busy, .address_lines, .chip_select_n, .output_enable_n,
      .write_strobe_n, .reset_or_unprotect_n, .byte_word_sel, .data_in, .data_out, .data_oe,
      .top_data_or_low_address_oe, .ready_busy_od);
   fabi_flash_model fabi_flash_model_i (.address_lines, .chip_select_n, .output_enable_n, .write_strobe_n,
      .reset_or_unprotect_n, .byte_word_sel, .data_out, .data_oe, .top_data_or_low_address_oe, .data_in,
      .ready_busy_od, .host_faults);
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // reset width, busy flag and hang guard
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (reset_or_unprotect_n === 1'b0) low_cnt <= low_cnt + 1;
      if (dev_busy === 1'b1) busy_seen <= 1'b1;
      if (cycles == 20000) begin
         fail_count++;
         $display("ERROR %0t: timeout", $time);
         complete_run();
      end
   end
   // reference array: unwritten cells erased, writes only clear bits
   function automatic logic [15:0] exp_rd(input logic [16:0] x, input logic hi, input logic wm);
      logic [15:0] w;
      w = exp_mem.exists(x) ? exp_mem[x] : 16'hFFFF;
      return wm ? w : {8'h00, hi ? w[15:8] : w[7:0]};
   endfunction
   // one request held until answered; a reset counts as taken once the pin falls
   task automatic op(input fabi_op_type o, input logic [16:0] x, input logic hi, input logic [15:0] wd, input logic wm);
      int n;
      n = 0;
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req_op <= o;
      req_addr <= x;
      req_byte_high <= hi;
      req_wdata <= wd;
      word_mode <= wm;
      do begin
         @(posedge ref_clk);
         n++;
      end while (n < 300 && (o == FABI_OP_RESET ? reset_or_unprotect_n !== 1'b0 : rsp_valid !== 1'b1));
      req_valid <= 1'b0;
      if (n >= 300) begin
         fail_count++;
         $display("ERROR %0t: no answer to request", $time);
      end
      if (o == FABI_OP_WRITE) exp_mem[x] = exp_rd(x, 1'b0, 1'b1) & (wm ? wd : hi ? {wd[7:0], 8'hFF} : {8'hFF, wd[7:0]});
   endtask
   initial begin
      void'($urandom(45));
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      // erased array at every block edge after power up
      foreach (edges[i]) begin
         op(FABI_OP_READ, edges[i], 1'b0, 16'h0000, 1'b1);
         `CHK(rsp_rdata, 16'hFFFF)
      end
      // word writes over a small pool so cells get rewritten
      repeat (12) begin
         a = 17'($urandom) & 17'h18003;
         d = 16'($urandom);
         op(FABI_OP_WRITE, a, 1'b0, d, 1'b1);
         op(FABI_OP_READ, a, 1'b0, 16'h0000, 1'b1);
         `CHK(rsp_rdata, exp_rd(a, 1'b0, 1'b1))
      end
      // byte mode: top pin picks the byte, upper lines unused
      repeat (8) begin
         a = 17'($urandom) & 17'h18003;
         bh = 1'($urandom);
         d = 16'($urandom);
         op(FABI_OP_WRITE, a, bh, d, 1'b0);
         for (int h = 0; h < 2; h++) begin
            op(FABI_OP_READ, a, 1'(h), 16'h0000, 1'b0);
            `CHK(rsp_rdata, exp_rd(a, 1'(h), 1'b0))
         end
         op(FABI_OP_READ, a, 1'b0, 16'h0000, 1'b1);
         `CHK(rsp_rdata, exp_rd(a, 1'b0, 1'b1))
      end
      // hardware reset, then a read once recovery is over
      low_cnt = 0;
      busy_seen = 1'b0;
      op(FABI_OP_RESET, 17'h00000, 1'b0, 16'h0000, 1'b1);
      `CHK(req_ready, 1'b0)
      op(FABI_OP_READ, a, 1'b0, 16'h0000, 1'b1);
      `CHK(rsp_rdata, exp_rd(a, 1'b0, 1'b1))
      // the taking edge drops the pin one cycle ahead of the counted low state
      `CHK(low_cnt, RESET_LOW_CYC + 1)
      `CHK(busy_seen, 1'b1)
      `CHK(host_faults, 0)
      // idle, device ready and no request: ready shows one edge later
      repeat (3) @(posedge ref_clk);
      `CHK(req_ready, 1'b1)
      complete_run();
   end
endmodule
